// File: rtl/terminal_status_flags_defines.vh
`ifndef TERMINAL_STATUS_FLAGS_DEFINES_VH
`define TERMINAL_STATUS_FLAGS_DEFINES_VH

// Register byte offsets
`define OFS_STATUS      8'h00
`define OFS_IRQ_STATUS  8'h04
`define OFS_IRQ_MASK    8'h08
`define OFS_INIT_INFO   8'h0C

// Status register fields
`define BIT_MON_MSG     7
`define BIT_MON_PKT     6
`define BIT_T2_MSG      5
`define BIT_T1_MSG      4
`define BIT_T2_INH      3
`define BIT_T1_INH      2
`define BIT_CKSUM       1
`define BIT_RAM_INIT    0
`define BIT_T1_RESET    10
`define BIT_T2_RESET    11
`define NUM_FLAGS       8

// Interrupt status layout, shared with the mask
`define IRQ_CKSUM       14
`define IRQ_RAM_INIT    13
`define IRQ_USED        16'h600C

// Init info fields
`define INFO_AUTO_EN    0
`define INFO_T1_BUS     4
`define INFO_T2_BUS     5

// Reset values and responses
`define RST_FLAGS       8'h00
`define RST_MASK        16'h0000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// File: rtl/status_flag_cell.v
module status_flag_cell (
  input  wire aclk,
  input  wire aresetn,
  input  wire set_in,
  input  wire clr_in,
  output reg  flag_reg
);

  // Set beats a clear arriving in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else if (set_in) begin
      flag_reg <= 1'b1;
    end else if (clr_in) begin
      flag_reg <= 1'b0;
    end
  end

endmodule

// File: rtl/terminal_status_flags.v
`include "terminal_status_flags_defines.vh"

module terminal_status_flags #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              auto_init_enable_pin,
  input  wire              mon_packet_start,
  input  wire              mon_packet_done,
  input  wire              mon_cmd_valid,
  input  wire              mon_msg_done,
  input  wire              t1_cmd_valid,
  input  wire              t1_msg_done,
  input  wire              t2_cmd_valid,
  input  wire              t2_msg_done,
  input  wire              t1_shutdown_cmd,
  input  wire              t1_override_cmd,
  input  wire              t1_shutdown_bus,
  input  wire              t2_shutdown_cmd,
  input  wire              t2_override_cmd,
  input  wire              t2_shutdown_bus,
  input  wire              checksum_fail,
  input  wire              ram_mismatch_fail,
  output wire              monitor_packet_in_progress,
  output wire              monitor_message_in_progress,
  output wire              terminal_one_message_active,
  output wire              terminal_two_message_active,
  output wire              terminal_one_bus_inhibited,
  output wire              terminal_two_bus_inhibited,
  output wire              eeprom_checksum_error,
  output wire              ram_init_mismatch,
  output reg               terminal_one_soft_reset,
  output reg               terminal_two_soft_reset,
  output reg               hw_pend_checksum,
  output reg               hw_pend_ram_init,
  output reg               t1_inhibited_bus_reg,
  output reg               t2_inhibited_bus_reg,
  output reg               auto_init_enable_reg,
  output wire              irq
);

  wire [`NUM_FLAGS-1:0] flag_set;
  wire [`NUM_FLAGS-1:0] flag_clr;
  wire [`NUM_FLAGS-1:0] flags;

  reg                   aw_full_reg;
  reg  [ADDR_W-1:0]     aw_addr_reg;
  reg                   w_full_reg;
  reg  [31:0]           w_data_reg;
  reg  [3:0]            w_strb_reg;
  reg                   capture_pending_reg;
  reg  [15:0]           irq_status_reg;
  reg  [15:0]           irq_status_next;
  reg  [15:0]           irq_mask_reg;
  reg  [31:0]           rdata_next;
  reg  [1:0]            rresp_next;
  reg                   wr_decode_ok;

  localparam [15:0]     IRQ_USED_MASK = `IRQ_USED;

  wire                  do_write;
  wire                  do_read;
  wire [15:0]           irq_event;
  wire                  wr_status;
  wire                  wr_irq_status;
  wire                  wr_irq_mask;
  wire                  t1_reset_req;
  wire                  t2_reset_req;

  // Bus handshake
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;

  // Address and data may arrive in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end
  end

  // Write decode
  always @* begin
    case (aw_addr_reg)
      `OFS_STATUS: begin
        wr_decode_ok = 1'b1;
      end
      `OFS_IRQ_STATUS: begin
        wr_decode_ok = 1'b1;
      end
      `OFS_IRQ_MASK: begin
        wr_decode_ok = 1'b1;
      end
      `OFS_INIT_INFO: begin
        wr_decode_ok = 1'b1;
      end
      default: begin
        wr_decode_ok = 1'b0;
      end
    endcase
  end

  assign wr_status     = do_write && (aw_addr_reg == `OFS_STATUS);
  assign wr_irq_status = do_write && (aw_addr_reg == `OFS_IRQ_STATUS);
  assign wr_irq_mask   = do_write && (aw_addr_reg == `OFS_IRQ_MASK);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_decode_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Soft reset requests live in byte lane 1 (bits 15:8)
  assign t1_reset_req = wr_status && w_strb_reg[1] && w_data_reg[`BIT_T1_RESET];
  assign t2_reset_req = wr_status && w_strb_reg[1] && w_data_reg[`BIT_T2_RESET];

  // One-cycle pulses; the soft reset engine itself sits elsewhere
  always @(posedge aclk) begin
    if (!aresetn) begin
      terminal_one_soft_reset <= 1'b0;
      terminal_two_soft_reset <= 1'b0;
    end else begin
      terminal_one_soft_reset <= t1_reset_req;
      terminal_two_soft_reset <= t2_reset_req;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      capture_pending_reg  <= 1'b1;
      auto_init_enable_reg <= 1'b0;
    end else if (capture_pending_reg) begin
      capture_pending_reg  <= 1'b0;
      auto_init_enable_reg <= auto_init_enable_pin;
    end
  end

  assign flag_set[`BIT_MON_MSG]  = mon_cmd_valid;
  assign flag_clr[`BIT_MON_MSG]  = mon_msg_done;
  assign flag_set[`BIT_MON_PKT]  = mon_packet_start;
  assign flag_clr[`BIT_MON_PKT]  = mon_packet_done;
  assign flag_set[`BIT_T2_MSG]   = t2_cmd_valid;
  assign flag_clr[`BIT_T2_MSG]   = t2_msg_done;
  assign flag_set[`BIT_T1_MSG]   = t1_cmd_valid;
  assign flag_clr[`BIT_T1_MSG]   = t1_msg_done;
  assign flag_set[`BIT_T2_INH]   = t2_shutdown_cmd;
  // Override or soft reset ends it
  assign flag_clr[`BIT_T2_INH]   = t2_override_cmd || t2_reset_req;
  assign flag_set[`BIT_T1_INH]   = t1_shutdown_cmd;
  // Override or soft reset ends it
  assign flag_clr[`BIT_T1_INH]   = t1_override_cmd || t1_reset_req;
  assign flag_set[`BIT_CKSUM]    = checksum_fail && auto_init_enable_reg;
  assign flag_clr[`BIT_CKSUM]    = 1'b0;
  assign flag_set[`BIT_RAM_INIT] = ram_mismatch_fail && auto_init_enable_reg;
  assign flag_clr[`BIT_RAM_INIT] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_FLAGS; gi = gi + 1) begin : g_flag
      status_flag_cell u_cell (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .set_in   (flag_set[gi]),
        .clr_in   (flag_clr[gi]),
        .flag_reg (flags[gi])
      );
    end
  endgenerate

  assign monitor_message_in_progress = flags[`BIT_MON_MSG];
  assign monitor_packet_in_progress  = flags[`BIT_MON_PKT];
  assign terminal_two_message_active = flags[`BIT_T2_MSG];
  assign terminal_one_message_active = flags[`BIT_T1_MSG];
  assign terminal_two_bus_inhibited  = flags[`BIT_T2_INH];
  assign terminal_one_bus_inhibited  = flags[`BIT_T1_INH];
  assign eeprom_checksum_error       = flags[`BIT_CKSUM];
  assign ram_init_mismatch           = flags[`BIT_RAM_INIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      t1_inhibited_bus_reg <= 1'b0;
      t2_inhibited_bus_reg <= 1'b0;
    end else begin
      if (t1_shutdown_cmd) begin
        t1_inhibited_bus_reg <= t1_shutdown_bus;
      end
      if (t2_shutdown_cmd) begin
        t2_inhibited_bus_reg <= t2_shutdown_bus;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      hw_pend_checksum <= 1'b0;
      hw_pend_ram_init <= 1'b0;
    end else begin
      hw_pend_checksum <= flag_set[`BIT_CKSUM];
      hw_pend_ram_init <= flag_set[`BIT_RAM_INIT];
    end
  end

  // Local interrupt events
  assign irq_event = {1'b0,
                      flag_set[`BIT_CKSUM],
                      flag_set[`BIT_RAM_INIT],
                      9'h000,
                      flag_set[`BIT_T2_INH] && !flags[`BIT_T2_INH],
                      flag_set[`BIT_T1_INH] && !flags[`BIT_T1_INH],
                      2'h0};

  // Write-one-to-clear; a new event wins over the clear
  always @* begin
    irq_status_next = irq_status_reg;
    if (wr_irq_status) begin
      if (w_strb_reg[0]) begin
        irq_status_next[7:0] = irq_status_reg[7:0] & ~w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        irq_status_next[15:8] = irq_status_reg[15:8] & ~w_data_reg[15:8];
      end
    end
    irq_status_next = irq_status_next | irq_event;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 16'h0000;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= `RST_MASK;
    end else if (wr_irq_mask) begin
      if (w_strb_reg[0]) begin
        irq_mask_reg[7:0] <= w_data_reg[7:0] & IRQ_USED_MASK[7:0];
      end
      if (w_strb_reg[1]) begin
        irq_mask_reg[15:8] <= w_data_reg[15:8] & IRQ_USED_MASK[15:8];
      end
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read mux; unused and upper bits read zero
  always @* begin
    rdata_next = 32'h00000000;
    rresp_next = `RESP_OKAY;
    case (s_axi_araddr)
      `OFS_STATUS: begin
        rdata_next[`NUM_FLAGS-1:0] = flags;
      end
      `OFS_IRQ_STATUS: begin
        rdata_next[15:0] = irq_status_reg;
      end
      `OFS_IRQ_MASK: begin
        rdata_next[15:0] = irq_mask_reg;
      end
      `OFS_INIT_INFO: begin
        rdata_next[`INFO_AUTO_EN] = auto_init_enable_reg;
        rdata_next[`INFO_T1_BUS]  = t1_inhibited_bus_reg;
        rdata_next[`INFO_T2_BUS]  = t2_inhibited_bus_reg;
      end
      default: begin
        rresp_next = `RESP_SLVERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_next;
      s_axi_rresp  <= rresp_next;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: verif/terminal_status_flags_monitor.sv
module tsf_monitor (
  input wire logic aclk,
  aresetn,
  mon_packet_start,
  mon_packet_done,
  mon_cmd_valid,
  mon_msg_done,
  t1_cmd_valid,
  t1_msg_done,
  t2_cmd_valid,
  t2_msg_done,
  t1_shutdown_cmd,
  t1_override_cmd,
  t2_shutdown_cmd,
  t2_override_cmd,
  checksum_fail,
  ram_mismatch_fail,
  auto_init_enable_reg,
  monitor_packet_in_progress,
  monitor_message_in_progress,
  terminal_one_message_active,
  terminal_two_message_active,
  terminal_one_bus_inhibited,
  terminal_two_bus_inhibited,
  eeprom_checksum_error,
  ram_init_mismatch,
  hw_pend_checksum,
  hw_pend_ram_init
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Set beats clear in the same cycle
  AST_PKT: assert property ((mon_packet_start | mon_packet_done) |=>
    monitor_packet_in_progress == $past(mon_packet_start)) else $error("packet flag");
  AST_MON_MSG: assert property ((mon_cmd_valid | mon_msg_done) |=>
    monitor_message_in_progress == $past(mon_cmd_valid)) else $error("monitor msg flag");
  AST_T2_MSG: assert property ((t2_cmd_valid | t2_msg_done) |=>
    terminal_two_message_active == $past(t2_cmd_valid)) else $error("t2 msg flag");
  AST_T1_MSG: assert property ((t1_cmd_valid | t1_msg_done) |=>
    terminal_one_message_active == $past(t1_cmd_valid)) else $error("t1 msg flag");
  AST_T2_INH: assert property (t2_shutdown_cmd ##1 1'b1 |-> terminal_two_bus_inhibited)
    else $error("t2 inhibit");
  AST_T2_END: assert property (t2_override_cmd && !t2_shutdown_cmd |=> !terminal_two_bus_inhibited)
    else $error("t2 override");
  AST_T1_INH: assert property ($rose(terminal_one_bus_inhibited) |-> $past(t1_shutdown_cmd))
    else $error("t1 inhibit cause");
  AST_T1_END: assert property (t1_override_cmd && !t1_shutdown_cmd |=> !terminal_one_bus_inhibited)
    else $error("t1 override");
  AST_GATE: assert property (!auto_init_enable_reg |-> !(eeprom_checksum_error | ram_init_mismatch))
    else $error("init flag without enable");
  AST_CK_SET: assert property (checksum_fail && auto_init_enable_reg |=>
    eeprom_checksum_error && hw_pend_checksum) else $error("checksum set");
  AST_RAM_SET: assert property (ram_mismatch_fail && auto_init_enable_reg |=>
    ram_init_mismatch && hw_pend_ram_init) else $error("ram mismatch set");
  AST_STICKY: assert property (eeprom_checksum_error |=> eeprom_checksum_error)
    else $error("checksum flag lost");
endmodule

bind terminal_status_flags tsf_monitor u_mon (.*);

// File: verif/axi_host_model.sv
module axi_host_model (
  input  wire logic        aclk,
  s_axi_awready,
  s_axi_wready,
  s_axi_bvalid,
  s_axi_arready,
  s_axi_rvalid,
  input  wire logic [1:0]  s_axi_bresp,
  s_axi_rresp,
  input  wire logic [31:0] s_axi_rdata,
  output logic      [7:0]  s_axi_awaddr,
  s_axi_araddr,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic      [2:0]  s_axi_awprot,
  s_axi_arprot,
  output logic             s_axi_awvalid,
  s_axi_wvalid,
  s_axi_bready,
  s_axi_arvalid,
  s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Handshakes judged at negedge: inputs only move after rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ka, kw, kb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ka = s_axi_awvalid & s_axi_awready;
      kw = s_axi_wvalid & s_axi_wready;
      kb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ka) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (kw) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!kb);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ka, kr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ka = s_axi_arvalid & s_axi_arready;
      kr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ka) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!kr);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

// File: verif/terminal_status_flags_bench.sv
module terminal_status_flags_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, auto_init_enable_pin, t1_shutdown_bus, t2_shutdown_bus, irq, en, b1, b2;
  logic [13:0] ev;
  logic [7:0] s_axi_awaddr, s_axi_araddr, fl;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv, rn;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] ist, msk;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic monitor_packet_in_progress, monitor_message_in_progress, terminal_one_message_active;
  logic terminal_two_message_active, terminal_one_bus_inhibited, terminal_two_bus_inhibited;
  logic eeprom_checksum_error, ram_init_mismatch, terminal_one_soft_reset, terminal_two_soft_reset;
  logic hw_pend_checksum, hw_pend_ram_init, t1_inhibited_bus_reg, t2_inhibited_bus_reg, auto_init_enable_reg;
  int n_errors = 0, n_compared = 0, cyc = 0, n_sr1 = 0, n_sr2 = 0;

  terminal_status_flags u_dut (.*, .mon_packet_start(ev[0]), .mon_packet_done(ev[1]), .mon_cmd_valid(ev[2]),
    .mon_msg_done(ev[3]), .t1_cmd_valid(ev[4]), .t1_msg_done(ev[5]), .t2_cmd_valid(ev[6]),
    .t2_msg_done(ev[7]), .t1_shutdown_cmd(ev[8]), .t1_override_cmd(ev[9]), .t2_shutdown_cmd(ev[10]),
    .t2_override_cmd(ev[11]), .checksum_fail(ev[12]), .ram_mismatch_fail(ev[13]));
  axi_host_model u_host (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Run should need about 1500 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    // Soft reset pulses last one cycle, so count them as they pass
    if (aresetn === 1'b1 && terminal_one_soft_reset === 1'b1) begin
      n_sr1 <= n_sr1 + 1;
    end
    if (aresetn === 1'b1 && terminal_two_soft_reset === 1'b1) begin
      n_sr2 <= n_sr2 + 1;
    end
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  // Set wins over clear in one cycle
  function automatic logic [7:0] nxt(logic [7:0] f, logic [13:0] e);
    nxt[7] = e[2] | (f[7] & ~e[3]);
    nxt[6] = e[0] | (f[6] & ~e[1]);
    nxt[5] = e[6] | (f[5] & ~e[7]);
    nxt[4] = e[4] | (f[4] & ~e[5]);
    nxt[3] = e[10] | (f[3] & ~e[11]);
    nxt[2] = e[8] | (f[2] & ~e[9]);
    nxt[1] = f[1] | (en & e[12]);
    nxt[0] = f[0] | (en & e[13]);
  endfunction

  task automatic mrst(input logic e);
    aresetn <= 1'b0;
    auto_init_enable_pin <= e;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    {fl, ist, msk, b1, b2} = '0;
    en = e;
  endtask

  task automatic step(input logic [13:0] e);
    logic [7:0] old;
    rn = $urandom;
    ev <= e;
    t1_shutdown_bus <= rn[0];
    t2_shutdown_bus <= rn[1];
    @(posedge aclk);
    ev <= '0;
    if (e[8]) b1 = rn[0];
    if (e[10]) b2 = rn[1];
    old = fl;
    fl = nxt(fl, e);
    ist[14] |= en & e[12];
    ist[13] |= en & e[13];
    ist[3:2] |= fl[3:2] & ~old[3:2];
  endtask

  task automatic verify;
    @(negedge aclk);
    chk({monitor_message_in_progress, monitor_packet_in_progress, terminal_two_message_active,
      terminal_one_message_active, terminal_two_bus_inhibited, terminal_one_bus_inhibited,
      eeprom_checksum_error, ram_init_mismatch}, fl);
    chk(irq, |(ist & msk));
    @(posedge aclk);
    u_host.rd(8'h00, rdv, resp);
    chk(rdv, {24'h0, fl});
    u_host.rd(8'h0C, rdv, resp);
    chk(rdv, {26'h0, b2, b1, 3'h0, en});
    u_host.rd(8'h04, rdv, resp);
    chk(rdv, {16'h0, ist});
  endtask

  initial begin
    void'($urandom(32'h26452555));
    {aresetn, t1_shutdown_bus, t2_shutdown_bus, ev} = '0;
    auto_init_enable_pin = 1'b1;
    en = 1'b1;
    mrst(1'b1);
    verify();
    u_host.wr(8'h08, 32'h0000_600C, resp);
    msk = 16'h600C;
    step(14'h1555);
    verify();
    step(14'h2AAA);
    verify();
    step(14'h3FFF);
    verify();
    repeat (120) begin
      step(14'($urandom & $urandom));
      verify();
    end
    step(14'h0500);
    // Flag bits ignore host writes
    u_host.wr(8'h00, 32'h0000_00FF, resp);
    chk(resp, 2'h0);
    verify();
    u_host.wr(8'h00, 32'h0000_0400, resp);
    fl[2] = 1'b0;
    chk(n_sr1, 1);
    verify();
    u_host.wr(8'h00, 32'h0000_0800, resp);
    fl[3] = 1'b0;
    chk(n_sr1, 1);
    chk(n_sr2, 1);
    verify();
    u_host.wr(8'h08, 32'h0000_0000, resp);
    msk = 16'h0;
    verify();
    u_host.wr(8'h04, 32'h0000_FFFF, resp);
    ist = 16'h0;
    verify();
    u_host.rd(8'h10, rdv, resp);
    chk(resp, 2'h2);
    u_host.wr(8'h14, 32'h0000_0C00, resp);
    chk(resp, 2'h2);
    chk(n_sr2, 1);
    // Enable low at reset release keeps init flags quiet
    step(14'h0500);
    mrst(1'b0);
    verify();
    step(14'h3000);
    verify();
    finish_test();
  end
endmodule
